// file: hdl/dpd_pkg.sv
package dpd_pkg;

  // Serial word and latch layout.
  localparam int WORD_W       = 22;
  localparam int SEL_LO_BIT   = 0;
  localparam int SEL_HI_BIT   = 1;
  localparam int R_LSB        = 2;
  localparam int R_W          = 14;
  localparam int PD_POL_BIT   = 17;
  localparam int CP_GAIN_BIT  = 18;
  localparam int TRI_BIT      = 19;
  localparam int MUX_LSB      = 20;
  localparam int MUX_W        = 2;
  localparam int A_LSB        = 2;
  localparam int A_W          = 6;
  localparam int B_LSB        = 9;
  localparam int B_W          = 11;
  localparam int PRESC_BIT    = 20;
  localparam int PWRDN_BIT    = 21;
  localparam int PRE_W        = 7;
  localparam int NSIDE        = 2;

  // Every latch is cleared at reset.
  localparam logic [WORD_W-1:0] LATCH_RST = 22'h000000;

  // Prescaler modulus pairs, low member of each pair.
  localparam logic [PRE_W-1:0] IF_P_BIT0 = 7'h08;
  localparam logic [PRE_W-1:0] IF_P_BIT1 = 7'h10;
  localparam logic [PRE_W-1:0] RF_P_BIT0 = 7'h40;
  localparam logic [PRE_W-1:0] RF_P_BIT1 = 7'h20;

  // Synchronised pin positions.
  localparam int NPIN      = 6;
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LOAD  = 2;
  localparam int PIN_REF   = 3;
  localparam int PIN_VCO0  = 4;

  // Latch destinations picked by the two low word bits.
  typedef enum logic [1:0] {
    LAT_IF_REF = 2'h0,
    LAT_IF_AB  = 2'h1,
    LAT_RF_REF = 2'h2,
    LAT_RF_AB  = 2'h3
  } dpd_latch_type;

  // Status multiplexer code held in each reference latch.
  typedef enum logic [1:0] {
    MUX_OFF   = 2'h0,
    MUX_LOCK  = 2'h1,
    MUX_RESET = 2'h2,
    MUX_LOW   = 2'h3
  } dpd_mux_type;

  // Power sequencing states of one side.
  typedef enum logic [1:0] {
    PWR_ON       = 2'h0,
    PWR_PUMP_OFF = 2'h1,
    PWR_DOWN     = 2'h3
  } dpd_pwr_type;

endpackage : dpd_pkg

// file: hdl/dpd_synth_ctrl.sv
// Overview of operation
// R1 - Each serial clock rising edge shifts one data bit into 22-bit register.
// R2 - Host sends words MSB first; latch-select bits arrive last.
// R3 - Load strobe rising edge copies shift register into selected latch.
// R4 - Select 00 IF ref, 01 IF AB, 10 RF ref, 11 RF AB.
// R5 - IF AB bit 20 picks prescaler 8/9 when 0, 16/17 when 1.
// R6 - RF AB bit 20 picks prescaler 64/65 when 0, 32/33 when 1.
// R7 - Prescaler with A and B counters divides by B times P plus A.
// R8 - B counter is 11 bits, divide values 1 to 2047.
// R9 - A counter is 6 bits, values 0 to 63.
// R10 - 14-bit reference counter divides reference by 1 to 16383.
// R11 - Phase comparator compares reference and N counter outputs.
// R12 - Lock detect on status pin: high with narrow low pulses when locked.
// R13 - Combined lock detect shows lock only when both loops locked.
// R14 - Counter reset clears side's R and N counters, tri-states its pump.
// R15 - After reset release N counter restarts aligned with R counter.
// R16 - RF pump gain bit one enables fastlock, status pin grounds resistor.
// R17 - Power-down with pump not tri-stated: tri-state pump, then power down.
// R18 - Power-down with pump already tri-stated acts on the latching strobe; code tests only the tri-state bit, not counter reset.
// R19 - Power-down holds dividers in load state and debiases input stage.
// R20 - Reference oscillator disabled only when both sides powered down.
// R21 - Shift register and latches keep working in every power-down mode.
// R22 - Latching zero into power-down bit resumes operation immediately.
// R23 - Extra shifted bits fall off the top; last 22 bits are kept.
module dpd_synth_ctrl
  import dpd_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic nrst,
  // Three-wire serial port pins.
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic load_strobe,
  // Reference and divided oscillator inputs.
  input  wire logic reference_input,
  input  wire logic if_vco_in,
  input  wire logic rf_vco_in,
  // Open-drain status pin, always driven low when enabled.
  output wire logic status_mux_output,
  output wire logic status_mux_oe,
  // IF charge pump controls.
  output wire logic if_pump_up,
  output wire logic if_pump_dn,
  output wire logic if_pump_tristate,
  output wire logic if_pump_gain,
  // RF charge pump controls.
  output wire logic rf_pump_up,
  output wire logic rf_pump_dn,
  output wire logic rf_pump_tristate,
  output wire logic rf_pump_gain,
  // Power state and fastlock outputs.
  output wire logic if_input_debias,
  output wire logic rf_input_debias,
  output wire logic ref_osc_disable,
  output wire logic fastlock_active
);

  // Pin synchroniser chain and edge history.
  logic [NPIN-1:0] pin_w;
  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] meta_nxt;
  logic [NPIN-1:0] sync_r;
  logic [NPIN-1:0] sync_nxt;
  logic [NPIN-1:0] prev_r;
  logic [NPIN-1:0] prev_nxt;
  logic [NPIN-1:0] rise_w;
  // Shift register and the four latches, indexed 0 for IF, 1 for RF.
  logic [WORD_W-1:0] sr_r;
  logic [WORD_W-1:0] sr_nxt;
  logic [WORD_W-1:0] ref_r   [NSIDE];
  logic [WORD_W-1:0] ref_nxt [NSIDE];
  logic [WORD_W-1:0] ab_r    [NSIDE];
  logic [WORD_W-1:0] ab_nxt  [NSIDE];
  logic              ld_rise;
  dpd_latch_type     sel_w;
  // Per-side results gathered for the pins.
  logic [NSIDE-1:0] up_out_w;
  logic [NSIDE-1:0] dn_out_w;
  logic [NSIDE-1:0] tri_w;
  logic [NSIDE-1:0] down_w;
  logic [NSIDE-1:0] pulse_w;
  logic             stat_oe_r;
  logic             stat_oe_nxt;
  assign pin_w = {rf_vco_in, if_vco_in, reference_input,
                  load_strobe, ser_data, ser_clk};
  // Every pin passes two flops; only the second one feeds the edge history.
  always_comb begin
    meta_nxt = pin_w;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end
  assign rise_w  = sync_r & ~prev_r;
  assign ld_rise = rise_w[PIN_LOAD];
  assign sel_w   = dpd_latch_type'(sr_r[SEL_HI_BIT:SEL_LO_BIT]);
  // Shifting and latching ignore power state, so a sleeping side can
  // always be woken through the same port.
  always_comb begin
    sr_nxt = sr_r;
    if (rise_w[PIN_SCLK]) begin
      sr_nxt = {sr_r[WORD_W-2:0], sync_r[PIN_SDATA]}; // R1 R2 R23 R21
    end
    for (int i = 0; i < NSIDE; i++) begin
      ref_nxt[i] = ref_r[i];
      ab_nxt[i]  = ab_r[i];
    end
    if (ld_rise) begin // R3 R21
      case (sel_w) // R4
        LAT_IF_REF: ref_nxt[0] = sr_r;
        LAT_IF_AB:  ab_nxt[0]  = sr_r;
        LAT_RF_REF: ref_nxt[1] = sr_r;
        LAT_RF_AB:  ab_nxt[1]  = sr_r;
        default:    ref_nxt[0] = ref_r[0];
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sr_r <= LATCH_RST;
      for (int i = 0; i < NSIDE; i++) begin
        ref_r[i] <= LATCH_RST;
        ab_r[i]  <= LATCH_RST;
      end
    end else begin
      sr_r <= sr_nxt;
      for (int i = 0; i < NSIDE; i++) begin
        ref_r[i] <= ref_nxt[i];
        ab_r[i]  <= ab_nxt[i];
      end
    end
  end
  // R and N dividers, comparator and power sequencer per side.
  genvar g;
  for (g = 0; g < NSIDE; g++) begin : side
    logic [R_W-1:0]   r_cnt_r;
    logic [R_W-1:0]   r_cnt_nxt;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic [A_W-1:0]   a_cnt_r;
    logic [A_W-1:0]   a_cnt_nxt;
    logic [B_W-1:0]   b_cnt_r;
    logic [B_W-1:0]   b_cnt_nxt;
    logic             up_r;
    logic             up_nxt;
    logic             dn_r;
    logic             dn_nxt;
    logic             oup_r;
    logic             oup_nxt;
    logic             odn_r;
    logic             odn_nxt;
    dpd_pwr_type      pwr_r;
    dpd_pwr_type      pwr_nxt;
    logic [R_W-1:0]   r_div;
    logic [A_W-1:0]   a_val;
    logic [B_W-1:0]   b_val;
    logic [PRE_W-1:0] p_val;
    logic [PRE_W-1:0] mod_w;
    logic             cnt_rst;
    logic             hold;
    logic             r_tick;
    logic             p_tick;
    logic             n_tick;
    logic             pd_bit;

    assign r_div   = ref_r[g][R_LSB +: R_W];
    assign a_val   = ab_r[g][A_LSB +: A_W];
    assign b_val   = ab_r[g][B_LSB +: B_W];
    assign p_val   = ab_r[g][PRESC_BIT] ?                              // R5 R6
                     ((g == 0) ? IF_P_BIT1 : RF_P_BIT1) :
                     ((g == 0) ? IF_P_BIT0 : RF_P_BIT0);
    // Swallow one extra input cycle while the A count is not yet reached.
    assign mod_w   = (a_cnt_r < a_val) ? p_val + 7'h01 : p_val;        // R7
    assign cnt_rst = dpd_mux_type'(ref_r[g][MUX_LSB +: MUX_W]) == MUX_RESET;
    assign hold    = cnt_rst || pwr_r == PWR_DOWN;                     // R14 R19
    assign pd_bit  = ab_nxt[g][PWRDN_BIT];
    assign tri_w[g]  = ref_r[g][TRI_BIT] || cnt_rst || pwr_r != PWR_ON;
    assign down_w[g] = pwr_r == PWR_DOWN;
    assign pulse_w[g] = up_r | dn_r;
    assign up_out_w[g] = oup_r;
    assign dn_out_w[g] = odn_r;
    // Dividers sit at zero while held, so both restart from zero
    // in the same core clock cycle in which the hold is released.
    always_comb begin
      r_cnt_nxt = r_cnt_r;
      pre_nxt   = pre_r;
      a_cnt_nxt = a_cnt_r;
      b_cnt_nxt = b_cnt_r;
      r_tick    = 1'b0;
      p_tick    = 1'b0;
      n_tick    = 1'b0;
      if (hold) begin // R15 R19
        r_cnt_nxt = '0;
        pre_nxt   = '0;
        a_cnt_nxt = '0;
        b_cnt_nxt = '0;
      end else begin
        if (rise_w[PIN_REF]) begin
          if ({1'b0, r_cnt_r} + 15'h0001 >= {1'b0, r_div}) begin // R10
            r_cnt_nxt = '0;
            r_tick    = 1'b1;
          end else begin
            r_cnt_nxt = r_cnt_r + 14'h0001;
          end
        end
        if (rise_w[PIN_VCO0 + g]) begin
          if ({1'b0, pre_r} + 8'h01 >= {1'b0, mod_w}) begin
            pre_nxt = '0;
            p_tick  = 1'b1;
          end else begin
            pre_nxt = pre_r + 7'h01;
          end
        end
        if (p_tick) begin
          if ({1'b0, b_cnt_r} + 12'h001 >= {1'b0, b_val}) begin // R8 R7
            b_cnt_nxt = '0;
            a_cnt_nxt = '0;
            n_tick    = 1'b1;
          end else begin
            b_cnt_nxt = b_cnt_r + 11'h001;
            if (a_cnt_r < a_val) begin
              a_cnt_nxt = a_cnt_r + 6'h01; // R9
            end
          end
        end
      end
    end
    // Comparator: each edge raises its flag; both high resets them.
    always_comb begin
      up_nxt = up_r | r_tick;
      dn_nxt = dn_r | n_tick;
      if ((up_nxt && dn_nxt) || hold) begin // R11
        up_nxt = 1'b0;
        dn_nxt = 1'b0;
      end
      oup_nxt = 1'b0;
      odn_nxt = 1'b0;
      if (!tri_w[g]) begin
        oup_nxt = ref_r[g][PD_POL_BIT] ? up_nxt : dn_nxt;
        odn_nxt = ref_r[g][PD_POL_BIT] ? dn_nxt : up_nxt;
      end
    end
    // Sequencer looks at next latch values so a pre-stated pump goes
    // down on the very strobe that latches the power-down bit.
    always_comb begin
      pwr_nxt = pwr_r;
      if (!pd_bit) begin
        pwr_nxt = PWR_ON; // R22
      end else begin
        case (pwr_r)
          PWR_ON: begin
            if (ref_nxt[g][TRI_BIT]) begin
              pwr_nxt = PWR_DOWN; // R18
            end else begin
              pwr_nxt = PWR_PUMP_OFF; // R17
            end
          end
          PWR_PUMP_OFF: pwr_nxt = PWR_DOWN; // R17
          PWR_DOWN:     pwr_nxt = PWR_DOWN;
          default:      pwr_nxt = PWR_ON;
        endcase
      end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        r_cnt_r <= '0;
        pre_r   <= '0;
        a_cnt_r <= '0;
        b_cnt_r <= '0;
        up_r    <= 1'b0;
        dn_r    <= 1'b0;
        oup_r   <= 1'b0;
        odn_r   <= 1'b0;
        pwr_r   <= PWR_ON;
      end else begin
        r_cnt_r <= r_cnt_nxt;
        pre_r   <= pre_nxt;
        a_cnt_r <= a_cnt_nxt;
        b_cnt_r <= b_cnt_nxt;
        up_r    <= up_nxt;
        dn_r    <= dn_nxt;
        oup_r   <= oup_nxt;
        odn_r   <= odn_nxt;
        pwr_r   <= pwr_nxt;
      end
    end
  end

  // Status pin: fastlock overrides, lock detect pulls low on comparator
  // activity; selecting lock on both sides yields the combined detector.
  always_comb begin
    stat_oe_nxt = 1'b0;
    if (ref_r[1][CP_GAIN_BIT]) begin
      stat_oe_nxt = 1'b1; // R16
    end else begin
      for (int i = 0; i < NSIDE; i++) begin
        case (dpd_mux_type'(ref_r[i][MUX_LSB +: MUX_W]))
          MUX_LOCK: stat_oe_nxt = stat_oe_nxt | pulse_w[i]; // R12 R13
          MUX_LOW:  stat_oe_nxt = 1'b1;
          default:  stat_oe_nxt = stat_oe_nxt;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stat_oe_r <= 1'b0;
    end else begin
      stat_oe_r <= stat_oe_nxt;
    end
  end
  // Pin drive; the pad only ever pulls low.
  assign status_mux_output = 1'b0;
  assign status_mux_oe     = stat_oe_r;
  assign if_pump_up        = up_out_w[0];
  assign if_pump_dn        = dn_out_w[0];
  assign if_pump_tristate  = tri_w[0];                    // R14 R17
  assign if_pump_gain      = ref_r[0][CP_GAIN_BIT];
  assign rf_pump_up        = up_out_w[1];
  assign rf_pump_dn        = dn_out_w[1];
  assign rf_pump_tristate  = tri_w[1];                    // R14 R17
  assign rf_pump_gain      = ref_r[1][CP_GAIN_BIT];
  assign if_input_debias   = down_w[0];                   // R19
  assign rf_input_debias   = down_w[1];                   // R19
  assign ref_osc_disable   = down_w[0] & down_w[1];       // R20
  assign fastlock_active   = ref_r[1][CP_GAIN_BIT];       // R16

endmodule : dpd_synth_ctrl

// file: tb/dpd_host_model.sv
module dpd_host_model
  import dpd_pkg::*;
(
  // Core clock, used only to pace the pins.
  input  wire logic core_clk,
  // Three-wire serial pins.
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 4;

  // Serial clock stands low between frames.
  initial begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
  end

  // Each pin level lasts four core clocks, above the three the sync needs.
  task pace;
    repeat (HOLD) @(posedge core_clk);
    #1;
  endtask : pace

  // One bit, set up a whole level ahead of the rising serial clock.
  task shift_bit(input logic b);
    ser_data = b;
    pace();
    ser_clk = 1'b1;
    pace();
    ser_clk = 1'b0;
  endtask : shift_bit

  // Top bit first, then the strobe; data shows garbage from before the strobe rises.
  task send_word(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      shift_bit(w[i]);
    end
    ser_data = ~w[0];
    pace();
    load_strobe = 1'b1;
    pace();
    load_strobe = 1'b0;
    pace();
  endtask : send_word
endmodule : dpd_host_model

// file: tb/dpd_synth_ctrl_properties.sv
module dpd_chk
  import dpd_pkg::*;
(
  // Clock, reset and load pin.
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load_strobe,
  // Status pin.
  input wire logic status_mux_output,
  input wire logic status_mux_oe,
  // Pump and power outputs.
  input wire logic if_pump_up,
  input wire logic if_pump_dn,
  input wire logic rf_pump_up,
  input wire logic rf_pump_dn,
  input wire logic if_pump_tristate,
  input wire logic rf_pump_tristate,
  input wire logic if_pump_gain,
  input wire logic rf_pump_gain,
  input wire logic if_input_debias,
  input wire logic rf_input_debias,
  input wire logic ref_osc_disable,
  input wire logic fastlock_active
);
  timeunit 1ns;
  timeprecision 1ns;

  // All checks live in the core clock domain and sleep during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_fastlock_gain: assert property ($rose(fastlock_active) |=> status_mux_oe)
    else $error("Status pin late when fastlock began.");
  a_fastlock_pin: assert property (
    fastlock_active && $past(fastlock_active, 2) |-> status_mux_oe)
    else $error("Status pin not grounded in fastlock.");
  a_pin_only_low: assert property (status_mux_output == 1'b0)
    else $error("Open-drain status pin driven high.");
  a_pump_exclusive: assert property (
    !(if_pump_up && if_pump_dn) && !(rf_pump_up && rf_pump_dn))
    else $error("Pump up and down active together.");
  a_tri_quiet: assert property (
    if_pump_tristate [*3] |-> !if_pump_up && !if_pump_dn)
    else $error("IF pump pulses while off.");
  a_debias_pump_off: assert property (
    (!if_input_debias || if_pump_tristate) &&
    (!rf_input_debias || rf_pump_tristate))
    else $error("Side powered down with pump on.");
  a_pd_order: assert property (
    $rose(if_input_debias) |-> $past(if_pump_tristate))
    else $error("IF powered down before pump was off.");
  a_osc_both: assert property (
    $stable(if_input_debias) && $stable(rf_input_debias) |->
    ref_osc_disable == (if_input_debias && rf_input_debias))
    else $error("Oscillator disable wrong for power state.");
  a_latch_on_load: assert property (
    $changed(rf_pump_gain) || $changed(if_pump_gain) |->
    $past(load_strobe, 3))
    else $error("Latch changed without a load strobe.");
  a_resume_load: assert property (
    $fell(if_input_debias) || $fell(rf_input_debias) |->
    $past(load_strobe, 3))
    else $error("Power-up without a load strobe.");
endmodule : dpd_chk

bind dpd_synth_ctrl dpd_chk dpd_chk_inst (.core_clk, .nrst, .load_strobe,
  .status_mux_output, .status_mux_oe, .if_pump_up, .if_pump_dn, .rf_pump_up,
  .rf_pump_dn, .if_pump_tristate, .rf_pump_tristate, .if_pump_gain,
  .rf_pump_gain, .if_input_debias, .rf_input_debias, .ref_osc_disable,
  .fastlock_active);

// file: tb/tb.sv
module tb
  import dpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst     = 1'b0;
  logic reference_input = 1'b0;
  logic if_vco_in = 1'b0;
  logic rf_vco_in = 1'b0;
  logic ser_clk, ser_data, load_strobe;
  logic status_mux_output, status_mux_oe, fastlock_active, ref_osc_disable;
  logic if_pump_up, if_pump_dn, if_pump_tristate, if_pump_gain;
  logic rf_pump_up, rf_pump_dn, rf_pump_tristate, rf_pump_gain;
  logic if_input_debias, rf_input_debias;
  int   mismatches = 0;
  int   compares   = 0;
  logic seen_oe;
  logic seen_pump;
  // Words and the outputs they leave: gains, fastlock, tristates, debias, osc.
  localparam logic [WORD_W-1:0] WORDS [10] = '{22'h040000, 22'h040002,
    22'h080002, 22'h200607, 22'h200605, 22'h200000, 22'h000605, 22'h000000,
    22'h000607, 22'h000002};
  localparam logic [7:0] EXPS [10] = '{8'h80, 8'he0, 8'h88, 8'h8a, 8'h9f,
    8'h1f, 8'h1a, 8'h0a, 8'h08, 8'h00};
  wire  [7:0] outs = {if_pump_gain, rf_pump_gain, fastlock_active,
    if_pump_tristate, rf_pump_tristate, if_input_debias, rf_input_debias,
    ref_osc_disable};

  // Core clock at 10 MHz.
  always #50 core_clk = ~core_clk;

  // Slow reference and oscillator edges keep the comparators busy.
  always begin
    repeat (4) @(posedge core_clk);
    #1 reference_input = ~reference_input;
  end
  always begin
    repeat (3) @(posedge core_clk);
    #1 if_vco_in = ~if_vco_in;
    rf_vco_in = ~if_vco_in;
  end

  dpd_host_model dpd_host_model_inst (.core_clk(core_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .load_strobe(load_strobe));

  dpd_synth_ctrl dpd_synth_ctrl_inst (.core_clk(core_clk), .nrst(nrst),
    .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
    .reference_input(reference_input), .if_vco_in(if_vco_in),
    .rf_vco_in(rf_vco_in), .status_mux_output(status_mux_output),
    .status_mux_oe(status_mux_oe), .if_pump_up(if_pump_up),
    .if_pump_dn(if_pump_dn), .if_pump_tristate(if_pump_tristate),
    .if_pump_gain(if_pump_gain), .rf_pump_up(rf_pump_up),
    .rf_pump_dn(rf_pump_dn), .rf_pump_tristate(rf_pump_tristate),
    .rf_pump_gain(rf_pump_gain), .if_input_debias(if_input_debias),
    .rf_input_debias(rf_input_debias), .ref_osc_disable(ref_osc_disable),
    .fastlock_active(fastlock_active));

  // Counts one comparison and reports a mismatch at once.
  task check(input logic [7:0] exp);
    compares++;
    if (outs !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, outs);
    end
  endtask : check

  // Compares one status level against its expected value.
  task check_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_pin

  // Single exit point for the whole run.
  task conclude;
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // A hung run is cut short and counted as a failure.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  // Table walk, then the awkward cases.
  initial begin
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 10; i++) begin
      dpd_host_model_inst.send_word(WORDS[i]);
      check(EXPS[i]);
    end
    // Two surplus bits ahead of the word must fall off the top.
    dpd_host_model_inst.shift_bit(1'b1);
    dpd_host_model_inst.shift_bit(1'b1);
    dpd_host_model_inst.send_word(22'h040000);
    check(8'h80);
    // Power down both sides, then reset in mid-run.
    dpd_host_model_inst.send_word(22'h200605);
    dpd_host_model_inst.send_word(22'h200607);
    check(8'h9f);
    nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'b1;
    check(8'h00);
    // The port works again after reset: fastlock on, then off.
    dpd_host_model_inst.send_word(22'h040002);
    check(8'h60);
    check_pin(status_mux_oe, 1'b1);
    dpd_host_model_inst.send_word(22'h000002);
    check_pin(status_mux_oe, 1'b0);
    // IF lock detect: comparator activity pulls the pin and pulses the pump.
    dpd_host_model_inst.send_word(22'h100000);
    seen_oe   = 1'b0;
    seen_pump = 1'b0;
    for (int n = 0; n < 400; n++) begin
      @(posedge core_clk);
      #1 seen_oe = seen_oe | status_mux_oe;
      seen_pump = seen_pump | if_pump_up | if_pump_dn;
    end
    check_pin(seen_oe, 1'b1);
    check_pin(seen_pump, 1'b1);
    // Pin held low by its code, then the IF counters held in reset.
    dpd_host_model_inst.send_word(22'h300000);
    check_pin(status_mux_oe, 1'b1);
    dpd_host_model_inst.send_word(22'h200000);
    check(8'h10);
    conclude();
  end
endmodule : tb
